// ==== logic/dagbx_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module dagbx_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// mode status register bit
	input wire logic bit_reverse_mode,
	// generator requests
	input wire dagbx_pkg::dagbx_gen_req_t gen1_req,
	input wire dagbx_pkg::dagbx_gen_req_t gen2_req,
	// data access control
	input wire dagbx_pkg::dagbx_dsrc_t data_src,
	input wire logic [dagbx_pkg::ADDR_W-1:0] direct_addr,
	input wire logic data_access,
	input wire logic prog_data_access,
	input wire logic [dagbx_pkg::ADDR_W-1:0] fetch_addr,
	input wire logic fetch_access,
	input wire logic byte_access,
	input wire logic [dagbx_pkg::ADDR_W-1:0] byte_addr,
	// register moves and exchange
	input wire logic move_en,
	input wire logic [dagbx_pkg::REG_SEL_W-1:0] move_src,
	input wire logic [dagbx_pkg::REG_SEL_W-1:0] move_dst,
	input wire logic move_from_mem,
	input wire logic [dagbx_pkg::DDATA_W-1:0] mem_rd_data,
	input wire logic xchg_to_data,
	input wire logic xchg_to_prog,
	input wire logic [dagbx_pkg::PDATA_W-1:0] prog_rd_data,
	// internal buses
	output logic [dagbx_pkg::ADDR_W-1:0] data_address_bus,
	output logic [dagbx_pkg::ADDR_W-1:0] program_address_bus,
	output logic [dagbx_pkg::PDATA_W-1:0] program_data_bus,
	output logic [dagbx_pkg::DDATA_W-1:0] data_value_bus,
	output logic [dagbx_pkg::DDATA_W-1:0] move_result,
	// external bus
	output dagbx_pkg::dagbx_ext_t ext_bus,
	output logic byte_space_select,
	output logic data_space_select,
	output logic program_space_select
);
	import dagbx_pkg::*;

	logic [ADDR_W-1:0] gen1_addr, gen2_addr;
	logic [EXT_W-1:0] bus_exchange_extension_ff;
	logic [DDATA_W-1:0] regs_ff [REG_NUM];
	logic [DDATA_W-1:0] move_result_ff;
	dagbx_ext_t ext_ff, nxt_ext;

	// ----------------------------------------
	// address generators
	// ----------------------------------------
	// both run every cycle so two operands can be addressed at once
	dagbx_addr_gen #(.NPTR(PTR_NUM), .CAN_REVERSE(1'b1)) u_first_address_generator (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.req(gen1_req),
		.reverse_en(bit_reverse_mode),
		.addr(gen1_addr)
	);
	dagbx_addr_gen #(.NPTR(PTR_NUM), .CAN_REVERSE(1'b0)) u_second_address_generator (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.req(gen2_req),
		.reverse_en(1'b0),
		.addr(gen2_addr)
	);

	// ----------------------------------------
	// address buses
	// ----------------------------------------
	always_comb begin
		unique case (data_src)
			DAGBX_SRC_GEN1: data_address_bus = gen1_addr;
			DAGBX_SRC_GEN2: data_address_bus = gen2_addr;
			DAGBX_SRC_DIRECT: data_address_bus = direct_addr;
			default: data_address_bus = direct_addr;
		endcase
	end

	// program data reads take only the second generator, never a direct value
	assign program_address_bus = prog_data_access ? gen2_addr : fetch_addr;

	// ----------------------------------------
	// data buses and exchange unit
	// ----------------------------------------
	always_comb begin
		if (xchg_to_data) begin
			data_value_bus = prog_rd_data[PDATA_W-1:EXT_W];
		end else if (move_from_mem) begin
			data_value_bus = mem_rd_data;
		end else begin
			data_value_bus = regs_ff[move_src];
		end
	end

	// low 8 bits come from the extension register when going to the wide bus
	assign program_data_bus = xchg_to_prog ? {data_value_bus, bus_exchange_extension_ff} : prog_rd_data;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_exchange_extension_ff <= EXT_RST;
		end else if (xchg_to_data) begin
			bus_exchange_extension_ff <= prog_rd_data[EXT_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < REG_NUM; i++) begin
				regs_ff[i] <= REG_RST;
			end
			move_result_ff <= REG_RST;
		end else if (move_en) begin
			regs_ff[move_dst] <= data_value_bus;
			move_result_ff <= data_value_bus;
		end
	end
	assign move_result = move_result_ff;

	// ----------------------------------------
	// external bus multiplexing
	// ----------------------------------------
	// priority: program data, data, byte, instruction fetch
	always_comb begin
		nxt_ext = '0;
		if (prog_data_access) begin
			nxt_ext = '{1'b1, DAGBX_SP_PROG, program_address_bus, program_data_bus};
		end else if (data_access) begin
			nxt_ext = '{1'b1, DAGBX_SP_DATA, data_address_bus, {{EXT_W{1'b0}}, data_value_bus}};
		end else if (byte_access) begin
			nxt_ext = '{1'b1, DAGBX_SP_BYTE, byte_addr, {{EXT_W{1'b0}}, data_value_bus}};
		end else if (fetch_access) begin
			nxt_ext = '{1'b1, DAGBX_SP_PROG, fetch_addr, prog_rd_data};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_ff <= '0;
		end else begin
			ext_ff <= nxt_ext;
		end
	end
	assign ext_bus = ext_ff;
	assign byte_space_select = ext_ff.space == DAGBX_SP_BYTE;
	assign data_space_select = ext_ff.space == DAGBX_SP_DATA;
	assign program_space_select = ext_ff.space == DAGBX_SP_PROG;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_xchg_in;
		xchg_to_data ##1 xchg_to_prog;
	endsequence

	a_gen1_data_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
		prog_data_access |-> program_address_bus == gen2_addr) else $error("program data not from second generator");
	a_direct_addr_path: assert property (@(posedge ref_clk) disable iff (!rst_b)
		data_src == DAGBX_SRC_DIRECT |-> data_address_bus == direct_addr) else $error("direct address lost");
	a_gen1_addr_path: assert property (@(posedge ref_clk) disable iff (!rst_b)
		data_src == DAGBX_SRC_GEN1 |-> data_address_bus == gen1_addr) else $error("indirect address lost");
	a_exchange_round: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_xchg_in |-> program_data_bus[EXT_W-1:0] == $past(prog_rd_data[EXT_W-1:0])) else $error("extension lost");
	a_move_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
		move_en |=> move_result == $past(data_value_bus)) else $error("move not in one cycle");
	a_ext_prog_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
		prog_data_access |=> program_space_select && !data_space_select && ext_bus.addr == $past(gen2_addr))
		else $error("program space select wrong");
	a_ext_data_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!prog_data_access && data_access |=> data_space_select && !byte_space_select
		&& ext_bus.addr == $past(data_address_bus)) else $error("data space select wrong");
	a_one_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$onehot0({byte_space_select, data_space_select, program_space_select})
		&& ext_bus.ext_sel == (byte_space_select || data_space_select || program_space_select))
		else $error("two selects at once");
endmodule // dagbx_core
`default_nettype wire

// ==== pkg/dagbx_pkg.sv ====
`default_nettype none
package dagbx_pkg;
	// ----------------------------------------
	// widths and counts
	// ----------------------------------------
	localparam int ADDR_W = 14;
	localparam int PDATA_W = 24;
	localparam int DDATA_W = 16;
	localparam int EXT_W = PDATA_W - DDATA_W;
	localparam int PTR_NUM = 4;
	localparam int SEL_W = 2;
	localparam int REG_NUM = 8;
	localparam int REG_SEL_W = 3;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] PTR_RST = 14'h0000;
	localparam logic [ADDR_W-1:0] LEN_RST = 14'h0000;
	localparam logic [EXT_W-1:0] EXT_RST = 8'h00;
	localparam logic [DDATA_W-1:0] REG_RST = 16'h0000;

	typedef enum logic [1:0] {
		DAGBX_SRC_DIRECT = 2'h0,
		DAGBX_SRC_GEN1 = 2'h1,
		DAGBX_SRC_GEN2 = 2'h2
	} dagbx_dsrc_t;

	typedef enum logic [2:0] {
		DAGBX_SP_NONE = 3'h0,
		DAGBX_SP_BYTE = 3'h1,
		DAGBX_SP_DATA = 3'h2,
		DAGBX_SP_PROG = 3'h4
	} dagbx_space_t;

	// one generator request: use a pointer, post-modify it, or load it
	typedef struct packed {
		logic use_ptr;
		logic [SEL_W-1:0] ptr_sel;
		logic [SEL_W-1:0] mod_sel;
		logic load_ptr;
		logic load_mod;
		logic load_len;
		logic [SEL_W-1:0] load_sel;
		logic [ADDR_W-1:0] load_val;
	} dagbx_gen_req_t;

	typedef struct packed {
		logic ext_sel;
		dagbx_space_t space;
		logic [ADDR_W-1:0] addr;
		logic [PDATA_W-1:0] data;
	} dagbx_ext_t;
endpackage
`default_nettype wire

// ==== logic/dagbx_addr_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module dagbx_addr_gen #(
	parameter int NPTR = 4,
	parameter bit CAN_REVERSE = 1'b0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// request
	input wire dagbx_pkg::dagbx_gen_req_t req,
	input wire logic reverse_en,
	// address out
	output logic [dagbx_pkg::ADDR_W-1:0] addr
);
	import dagbx_pkg::*;

	logic [ADDR_W-1:0] ptr_ff [NPTR];
	logic [ADDR_W-1:0] mod_ff [NPTR];
	logic [ADDR_W-1:0] len_ff [NPTR];
	logic [ADDR_W-1:0] base_ff [NPTR];
	logic [ADDR_W-1:0] cur, md, ln, bs, nxt_ptr, mirrored;
	logic [ADDR_W:0] sum;

	assign cur = ptr_ff[req.ptr_sel];
	assign md = mod_ff[req.mod_sel];
	assign ln = len_ff[req.ptr_sel];
	assign bs = base_ff[req.ptr_sel];

	// ----------------------------------------
	// post-modify with circular wrap
	// ----------------------------------------
	always_comb begin
		sum = {1'b0, cur} + {1'b0, md};
		nxt_ptr = sum[ADDR_W-1:0];
		if (ln != '0) begin
			// modify treated signed: top bit set means step downward
			if (!md[ADDR_W-1] && (nxt_ptr >= ADDR_W'(bs + ln) || nxt_ptr < cur)) begin
				nxt_ptr = ADDR_W'(nxt_ptr - ln);
			end else if (md[ADDR_W-1] && (nxt_ptr < bs || nxt_ptr > cur)) begin
				nxt_ptr = ADDR_W'(nxt_ptr + ln);
			end
		end
	end

	// mirror all address bits
	always_comb begin
		for (int i = 0; i < ADDR_W; i++) begin
			mirrored[i] = cur[ADDR_W-1-i];
		end
	end

	assign addr = (CAN_REVERSE && reverse_en) ? mirrored : cur;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NPTR; i++) begin
				ptr_ff[i] <= PTR_RST;
				mod_ff[i] <= PTR_RST;
				len_ff[i] <= LEN_RST;
				base_ff[i] <= PTR_RST;
			end
		end else begin
			// a load wins over a post-modify of the same pointer
			if (req.use_ptr) begin
				ptr_ff[req.ptr_sel] <= nxt_ptr;
			end
			if (req.load_ptr) begin
				ptr_ff[req.load_sel] <= req.load_val;
				base_ff[req.load_sel] <= req.load_val;
			end
			if (req.load_mod) begin
				mod_ff[req.load_sel] <= req.load_val;
			end
			if (req.load_len) begin
				len_ff[req.load_sel] <= req.load_val;
			end
		end
	end

	a_wrap_stays_inside: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.use_ptr && !req.load_ptr && !req.load_len && ln != '0 && !md[ADDR_W-1]
		&& md < ln && cur >= bs && cur < ADDR_W'(bs + ln)
		|=> ptr_ff[$past(req.ptr_sel)] >= $past(bs)
		&& ptr_ff[$past(req.ptr_sel)] < ADDR_W'($past(bs) + $past(ln))) else $error("pointer left its buffer");
	a_linear_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
		req.use_ptr && !req.load_ptr && ln == '0
		|=> ptr_ff[$past(req.ptr_sel)] == ADDR_W'($past(cur) + $past(md))) else $error("linear step wrong");
	a_reverse_out: assert property (@(posedge ref_clk) disable iff (!rst_b)
		CAN_REVERSE && reverse_en |-> addr[0] == cur[ADDR_W-1] && addr[ADDR_W-1] == cur[0])
		else $error("bit reverse wrong");
endmodule // dagbx_addr_gen
`default_nettype wire

// ==== tb/dagbx_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dagbx_mem_model (
	// addresses from the core
	input wire logic [dagbx_pkg::ADDR_W-1:0] prog_addr,
	input wire logic [dagbx_pkg::ADDR_W-1:0] data_addr,
	// read data back
	output logic [dagbx_pkg::PDATA_W-1:0] prog_word,
	output logic [dagbx_pkg::DDATA_W-1:0] data_word
);
	import dagbx_pkg::*;
	// ----------------------------------------
	// memory contents
	// ----------------------------------------
	// words derive from the address, so every location differs without a stored array
	assign prog_word = {prog_addr, 10'h155};
	assign data_word = {2'h2, data_addr};
endmodule // dagbx_mem_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dagbx_pkg::*;
	typedef struct packed {
		logic [3:0] acc;
		logic [2:0] sel;
		logic [ADDR_W-1:0] addr;
	} dagbx_row_t;
	logic ref_clk, rst_b, bit_reverse_mode, data_access, prog_data_access, fetch_access, byte_access;
	logic move_en, move_from_mem, xchg_to_data, xchg_to_prog, byte_space_select, data_space_select;
	logic program_space_select;
	dagbx_gen_req_t g1, g2;
	dagbx_dsrc_t data_src;
	dagbx_ext_t ext_bus;
	logic [ADDR_W-1:0] direct_addr, fetch_addr, byte_addr, data_address_bus, program_address_bus, e;
	logic [REG_SEL_W-1:0] move_src, move_dst;
	logic [DDATA_W-1:0] mem_rd_data, data_value_bus, move_result;
	logic [PDATA_W-1:0] prog_rd_data, program_data_bus, pw;
	dagbx_row_t rows [5];
	int err_count, n_tests, cyc;

	dagbx_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .bit_reverse_mode(bit_reverse_mode), .gen1_req(g1),
		.gen2_req(g2), .data_src(data_src), .direct_addr(direct_addr), .data_access(data_access),
		.prog_data_access(prog_data_access), .fetch_addr(fetch_addr), .fetch_access(fetch_access),
		.byte_access(byte_access), .byte_addr(byte_addr), .move_en(move_en), .move_src(move_src),
		.move_dst(move_dst), .move_from_mem(move_from_mem), .mem_rd_data(mem_rd_data),
		.xchg_to_data(xchg_to_data), .xchg_to_prog(xchg_to_prog), .prog_rd_data(prog_rd_data),
		.data_address_bus(data_address_bus), .program_address_bus(program_address_bus),
		.program_data_bus(program_data_bus), .data_value_bus(data_value_bus), .move_result(move_result),
		.ext_bus(ext_bus), .byte_space_select(byte_space_select), .data_space_select(data_space_select),
		.program_space_select(program_space_select));
	dagbx_mem_model mem (.prog_addr(program_address_bus), .data_addr(data_address_bus),
		.prog_word(prog_rd_data), .data_word(mem_rd_data));

	always #12.5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [ADDR_W-1:0] rev14(input logic [ADDR_W-1:0] a);
		for (int i = 0; i < ADDR_W; i++) rev14[i] = a[ADDR_W-1-i];
	endfunction

	task automatic tick();
		@(negedge ref_clk);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// hang guard
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 400) begin
			err_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0; rst_b = 1'b0; bit_reverse_mode = 1'b0; g1 = '0; g2 = '0; data_src = DAGBX_SRC_DIRECT;
		{data_access, prog_data_access, fetch_access, byte_access} = 4'h0;
		{move_en, move_from_mem, xchg_to_data, xchg_to_prog} = 4'h0;
		direct_addr = 14'h0005; byte_addr = 14'h0123; fetch_addr = 14'h3FFF; move_src = 3'h0; move_dst = 3'h0;
		rows = '{'{4'h8, 3'h2, 14'h0005}, '{4'h2, 3'h4, 14'h0123}, '{4'h1, 3'h1, 14'h3FFF},
			'{4'h3, 3'h4, 14'h0123}, '{4'hC, 3'h1, 14'h0000}};
		repeat (12) tick();
		rst_b = 1'b1;
		chk("dir addr", 24'(data_address_bus), 24'h000005);
		// back-to-back external accesses, priority among simultaneous ones
		foreach (rows[i]) begin
			{data_access, prog_data_access, byte_access, fetch_access} = rows[i].acc;
			tick();
			chk("selects", 24'({byte_space_select, data_space_select, program_space_select}), 24'(rows[i].sel));
			chk("ext addr", 24'(ext_bus.addr), 24'(rows[i].addr));
		end
		{data_access, prog_data_access, byte_access, fetch_access} = 4'h0;
		tick();
		chk("idle sel", 24'({byte_space_select, data_space_select, program_space_select}), 24'h0);
		// both generators: buffer base 10, length 4, modify +1
		g1.load_ptr = 1'b1; g1.load_val = 14'h000A; g2 = g1; tick();
		g1 = '0; g1.load_len = 1'b1; g1.load_val = 14'h0004; g2 = g1; tick();
		g1 = '0; g1.load_mod = 1'b1; g1.load_val = 14'h0001; g2 = g1; tick();
		g1 = '0; g1.use_ptr = 1'b1; g2 = g1;
		data_src = DAGBX_SRC_GEN1; prog_data_access = 1'b1; bit_reverse_mode = 1'b1;
		for (int i = 0; i < 6; i++) begin
			e = 14'(10 + i % 4);
			#1;
			chk("gen1 rev", 24'(data_address_bus), 24'(rev14(e)));
			chk("gen2 addr", 24'(program_address_bus), 24'(e));
			tick();
		end
		// negative modify drops below the base and wraps up by the length
		bit_reverse_mode = 1'b0;
		// meanwhile the second generator loads pointer 3 and steps it with no length
		g1 = '0; g1.load_mod = 1'b1; g1.load_val = 14'h3FFF;
		g2 = '0; g2.load_ptr = 1'b1; g2.load_sel = 2'h3; g2.load_val = 14'h1234;
		tick();
		g1 = '0; g1.use_ptr = 1'b1;
		g2 = '0; g2.use_ptr = 1'b1; g2.ptr_sel = 2'h3;
		for (int i = 0; i < 4; i++) begin
			e = (i == 3) ? 14'h000D : 14'(12 - i);
			#1;
			chk("gen1 down", 24'(data_address_bus), 24'(e));
			chk("gen2 ptr3", 24'(program_address_bus), 24'h001234 + 24'(i));
			tick();
		end
		g2.use_ptr = 1'b0; data_src = DAGBX_SRC_GEN2;
		#1;
		chk("gen2 data", 24'(data_address_bus), 24'h001238);
		tick();
		// exchange across the width gap, then register moves
		g1 = '0; prog_data_access = 1'b0; data_src = DAGBX_SRC_DIRECT; fetch_addr = 14'h2AF3;
		pw = {14'h2AF3, 10'h155};
		xchg_to_data = 1'b1; move_en = 1'b1; move_dst = 3'h3;
		#1;
		chk("dvb high", 24'(data_value_bus), 24'(pw[23:8]));
		tick();
		xchg_to_data = 1'b0; move_en = 1'b0; move_src = 3'h3; xchg_to_prog = 1'b1;
		#1;
		chk("pdb join", program_data_bus, pw);
		chk("move res", 24'(move_result), 24'(pw[23:8]));
		// hold the request over an edge so the round trip reaches the checks
		tick();
		xchg_to_prog = 1'b0; move_en = 1'b1; move_from_mem = 1'b1; move_dst = 3'h5;
		tick();
		chk("mem move", 24'(move_result), 24'h008005);
		move_from_mem = 1'b0; move_src = 3'h5; move_dst = 3'h6;
		tick();
		chk("reg move", 24'(move_result), 24'h008005);
		move_en = 1'b0; move_src = 3'h6;
		#1;
		chk("reg read", 24'(data_value_bus), 24'h008005);
		tick();
		data_access = 1'b1;
		tick();
		chk("ext data", 24'(ext_bus.data), 24'h008005);
		chk("ext sel", 24'(ext_bus.ext_sel), 24'h000001);
		// reset in mid-request clears the external bus at once
		rst_b = 1'b0;
		#1;
		chk("rst sel", 24'({byte_space_select, data_space_select, program_space_select}), 24'h0);
		chk("rst addr", 24'(ext_bus.addr), 24'h0);
		tick();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
